/* rtl/i2c_status_pkg.sv */
// Constants and state types for the two-wire status flag block
package i2c_status_pkg;
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] TX_BUFFER_OFS = 8'h08;
  localparam logic [7:0] RX_BUFFER_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
  localparam int ACK_RESULT_BIT = 15;
  localparam int MASTER_TX_BIT = 14;
  localparam int ACK_WINDOW_BIT = 13;
  localparam int BUS_COLLISION_BIT = 10;
  localparam int GENERAL_CALL_BIT = 9;
  localparam int WRITE_COLLISION_BIT = 7;
  localparam int RX_OVERFLOW_BIT = 6;
  localparam int ENABLE_BIT = 0;
  localparam int IRQ_W = 6;
  localparam int IRQ_NACK = 0;
  localparam int IRQ_COLLISION = 1;
  localparam int IRQ_GENERAL_CALL = 2;
  localparam int IRQ_WRITE_COLLISION = 3;
  localparam int IRQ_OVERFLOW = 4;
  localparam int IRQ_BYTE_DONE = 5;
  localparam logic [3:0] ACK_EDGE_COUNT = 4'h9;
  localparam logic [3:0] LAST_DATA_EDGE = 4'h8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [5:0] IRQ_RESET = 6'h00;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic q;
  } sync_s;

  typedef struct packed {
    logic ack_result_flag;
    logic master_tx_active;
    logic ack_window_flag;
    logic bus_collision_flag;
    logic general_call_flag;
    logic tx_write_collision;
    logic rx_overflow_flag;
    logic controller_enable;
    logic [3:0] bit_count;
    logic rx_full;
    logic [7:0] rx_buffer;
    logic [7:0] tx_buffer;
    logic tx_load;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] dat;
    logic scl_d;
    logic sda_d;
  } state_s;
endpackage : i2c_status_pkg

/* rtl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  output logic level_out
);
  i2c_status_pkg::sync_s s;
  i2c_status_pkg::sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.f1 = pin_in;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    // Change only once stages two and three agree
    if (s.f2 == s.f3) begin
      next_s.q = s.f3;
    end
  end

  // Idle bus is high, so reset to high
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '{f1: 1'b1, f2: 1'b1, f3: 1'b1, q: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign level_out = s.q;
endmodule : pin_sync

/* rtl/i2c_status_flags.sv */
// Status flags, buffers and Wishbone registers of a two-wire bus controller
`timescale 1ns/1ps
module i2c_status_flags #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic irq_out,
  input wire logic serial_clock_line_in,
  input wire logic serial_data_line_in,
  input wire logic master_mode_in,
  input wire logic slave_mode_in,
  input wire logic tx_mode_in,
  input wire logic tx_busy_in,
  input wire logic ack_sample_in,
  input wire logic ack_nack_in,
  input wire logic collision_in,
  input wire logic general_call_in,
  input wire logic rx_byte_in,
  input wire logic [7:0] rx_data_in,
  output logic [7:0] tx_data_out,
  output logic tx_load_out,
  output logic controller_enable_out
);
  // Offsets up to 0x14 need at least five address bits
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 8");
  end

  i2c_status_pkg::state_s s;
  i2c_status_pkg::state_s next_s;
  logic scl;
  logic sda;
  logic req;
  logic wr;
  logic rd;
  logic [7:0] adr;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic ninth_rise;
  logic tx_accept;
  logic tx_refuse;
  logic overflow_event;
  logic rx_read;
  logic [15:0] status_word;
  logic [i2c_status_pkg::IRQ_W-1:0] events;

  pin_sync u_scl_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(serial_clock_line_in),
    .level_out(scl)
  );

  pin_sync u_sda_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pin_in(serial_data_line_in),
    .level_out(sda)
  );

  always_comb begin
    adr = 8'h00;
    adr[ADDR_W-1:0] = wb_adr_in;
    req = wb_cyc_in && wb_stb_in && !s.ack;
    wr = req && wb_we_in;
    rd = req && !wb_we_in;
    scl_rise = scl && !s.scl_d;
    scl_fall = !scl && s.scl_d;
    start_seen = scl && s.scl_d && !sda && s.sda_d;
    stop_seen = scl && s.scl_d && sda && !s.sda_d;
    ninth_rise = scl_rise && (s.bit_count == i2c_status_pkg::LAST_DATA_EDGE);
    tx_accept = wr && wb_sel_in[0] && (adr == i2c_status_pkg::TX_BUFFER_OFS) && !tx_busy_in;
    tx_refuse = wr && wb_sel_in[0] && (adr == i2c_status_pkg::TX_BUFFER_OFS) && tx_busy_in;
    rx_read = rd && (adr == i2c_status_pkg::RX_BUFFER_OFS);
    // A read in the same cycle frees the buffer, so no overflow then
    overflow_event = rx_byte_in && s.rx_full && !rx_read && !tx_mode_in;
    status_word = 16'h0000;
    status_word[i2c_status_pkg::ACK_RESULT_BIT] = s.ack_result_flag;
    status_word[i2c_status_pkg::MASTER_TX_BIT] = s.master_tx_active;
    status_word[i2c_status_pkg::ACK_WINDOW_BIT] = s.ack_window_flag;
    status_word[i2c_status_pkg::BUS_COLLISION_BIT] = s.bus_collision_flag;
    status_word[i2c_status_pkg::GENERAL_CALL_BIT] = s.general_call_flag;
    status_word[i2c_status_pkg::WRITE_COLLISION_BIT] = s.tx_write_collision;
    status_word[i2c_status_pkg::RX_OVERFLOW_BIT] = s.rx_overflow_flag;
    events = '0;
    events[i2c_status_pkg::IRQ_NACK] = ack_sample_in && ack_nack_in;
    events[i2c_status_pkg::IRQ_COLLISION] = collision_in;
    events[i2c_status_pkg::IRQ_GENERAL_CALL] = general_call_in;
    events[i2c_status_pkg::IRQ_WRITE_COLLISION] = tx_refuse;
    events[i2c_status_pkg::IRQ_OVERFLOW] = overflow_event;
    events[i2c_status_pkg::IRQ_BYTE_DONE] = ninth_rise;
  end

  always_comb begin
    next_s = s;
    next_s.scl_d = scl;
    next_s.sda_d = sda;
    next_s.ack = req;
    next_s.tx_load = 1'b0;

    // Bit clock counter, restarted by start and stop
    if (start_seen || stop_seen) begin
      next_s.bit_count = 4'h0;
    end else if (ninth_rise) begin
      next_s.bit_count = 4'h0;
    end else if (scl_rise) begin
      next_s.bit_count = s.bit_count + 4'h1;
    end

    // Software clears first; hardware sets below win
    if (wr && adr == i2c_status_pkg::STATUS_OFS) begin
      if (wb_sel_in[1] && !wb_dat_in[i2c_status_pkg::BUS_COLLISION_BIT]) begin
        next_s.bus_collision_flag = 1'b0;
      end
      if (wb_sel_in[0] && !wb_dat_in[i2c_status_pkg::WRITE_COLLISION_BIT]) begin
        next_s.tx_write_collision = 1'b0;
      end
      if (wb_sel_in[0] && !wb_dat_in[i2c_status_pkg::RX_OVERFLOW_BIT]) begin
        next_s.rx_overflow_flag = 1'b0;
      end
    end
    if (wr && wb_sel_in[0] && adr == i2c_status_pkg::CONTROL_OFS) begin
      next_s.controller_enable = wb_dat_in[i2c_status_pkg::ENABLE_BIT];
    end
    if (wr && wb_sel_in[0] && adr == i2c_status_pkg::IRQ_MASK_OFS) begin
      next_s.irq_mask = wb_dat_in[i2c_status_pkg::IRQ_W-1:0];
    end

    if (ack_sample_in) begin
      next_s.ack_result_flag = ack_nack_in;
    end

    if (ninth_rise || !master_mode_in || stop_seen) begin
      next_s.master_tx_active = 1'b0;
    end
    if (tx_accept && master_mode_in) begin
      next_s.master_tx_active = 1'b1;
    end

    if (ninth_rise || !slave_mode_in) begin
      next_s.ack_window_flag = 1'b0;
    end else if (scl_fall && s.bit_count == i2c_status_pkg::LAST_DATA_EDGE) begin
      next_s.ack_window_flag = 1'b1;
    end

    if (!s.controller_enable) begin
      next_s.bus_collision_flag = 1'b0;
    end
    if (collision_in) begin
      next_s.bus_collision_flag = 1'b1;
    end

    if (stop_seen) begin
      next_s.general_call_flag = 1'b0;
    end
    if (general_call_in) begin
      next_s.general_call_flag = 1'b1;
    end

    if (tx_accept) begin
      next_s.tx_buffer = wb_dat_in[7:0];
      next_s.tx_load = 1'b1;
    end
    if (tx_refuse) begin
      next_s.tx_write_collision = 1'b1;
    end

    // Receive buffer empties on read
    if (rx_read) begin
      next_s.rx_full = 1'b0;
    end
    if (overflow_event) begin
      next_s.rx_overflow_flag = 1'b1;
    end else if (rx_byte_in) begin
      next_s.rx_buffer = rx_data_in;
      next_s.rx_full = 1'b1;
    end

    // Read data, and read-to-clear of interrupt status; new events win
    next_s.dat = i2c_status_pkg::WORD_RESET;
    if (rd) begin
      case (adr)
        i2c_status_pkg::STATUS_OFS: next_s.dat[15:0] = status_word;
        i2c_status_pkg::CONTROL_OFS: next_s.dat[0] = s.controller_enable;
        i2c_status_pkg::TX_BUFFER_OFS: next_s.dat[7:0] = s.tx_buffer;
        i2c_status_pkg::RX_BUFFER_OFS: next_s.dat[7:0] = s.rx_buffer;
        i2c_status_pkg::IRQ_STATUS_OFS: next_s.dat[i2c_status_pkg::IRQ_W-1:0] = s.irq_status;
        i2c_status_pkg::IRQ_MASK_OFS: next_s.dat[i2c_status_pkg::IRQ_W-1:0] = s.irq_mask;
        default: next_s.dat = i2c_status_pkg::WORD_RESET;
      endcase
    end
    if (rd && adr == i2c_status_pkg::IRQ_STATUS_OFS) begin
      next_s.irq_status = events;
    end else begin
      next_s.irq_status = s.irq_status | events;
    end
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '{
        scl_d: 1'b1,
        sda_d: 1'b1,
        bit_count: 4'h0,
        rx_buffer: i2c_status_pkg::BYTE_RESET,
        tx_buffer: i2c_status_pkg::BYTE_RESET,
        irq_status: i2c_status_pkg::IRQ_RESET,
        irq_mask: i2c_status_pkg::IRQ_RESET,
        dat: i2c_status_pkg::WORD_RESET,
        default: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_out = s.dat;
  assign wb_ack_out = s.ack;
  assign irq_out = s.irq;
  assign tx_data_out = s.tx_buffer;
  assign tx_load_out = s.tx_load;
  assign controller_enable_out = s.controller_enable;

  property p_ack_result;
    @(posedge clk_in) disable iff (!rst_b_in)
    ack_sample_in |=> s.ack_result_flag == $past(ack_nack_in);
  endproperty
  a_ack_result: assert property (p_ack_result) else $error("ack result wrong");

  property p_master_tx;
    @(posedge clk_in) disable iff (!rst_b_in)
    (tx_accept && master_mode_in) |=> s.master_tx_active && tx_load_out;
  endproperty
  a_master_tx: assert property (p_master_tx) else $error("master tx not set");

  property p_ack_window;
    @(posedge clk_in) disable iff (!rst_b_in)
    ninth_rise |=> !s.ack_window_flag && s.bit_count == 4'h0;
  endproperty
  a_ack_window: assert property (p_ack_window) else $error("ack window not cleared");

  property p_collision;
    @(posedge clk_in) disable iff (!rst_b_in)
    collision_in |=> s.bus_collision_flag ##1 (s.controller_enable || !s.bus_collision_flag
      || $past(collision_in));
  endproperty
  a_collision: assert property (p_collision) else $error("bus collision wrong");

  property p_general_call;
    @(posedge clk_in) disable iff (!rst_b_in)
    (stop_seen && !general_call_in) |=> !s.general_call_flag;
  endproperty
  a_general_call: assert property (p_general_call) else $error("general call kept");

  property p_write_collision;
    @(posedge clk_in) disable iff (!rst_b_in)
    tx_refuse |=> s.tx_write_collision && !tx_load_out && $stable(tx_data_out);
  endproperty
  a_write_collision: assert property (p_write_collision) else $error("wcol wrong");

  property p_overflow;
    @(posedge clk_in) disable iff (!rst_b_in)
    overflow_event |=> s.rx_overflow_flag && $stable(s.rx_buffer);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow wrong");

  property p_readonly;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr && adr == i2c_status_pkg::STATUS_OFS && !ack_sample_in) |=>
      s.ack_result_flag == $past(s.ack_result_flag);
  endproperty
  a_readonly: assert property (p_readonly) else $error("read-only bit changed");

  property p_irq;
    @(posedge clk_in) disable iff (!rst_b_in)
    ##1 irq_out == |(s.irq_status & s.irq_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
endmodule : i2c_status_flags

/* sim/i2c_far_end.sv */
// Behavioural far-side bus party driving the two bus lines
`timescale 1ns/1ps
module i2c_far_end (
  output logic scl_out,
  output logic sda_out
);
  // Pull-ups hold both lines high; clock stands still outside frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Non-blocking so a change on a clock edge is seen after it
  task start_cond();
    sda_out <= 1'b0;
    #32;
    scl_out <= 1'b0;
  endtask : start_cond
  // Data moves only while clock is low, 64 ns a bit
  task clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #16 sda_out <= ~sda_out;
      #16 scl_out <= 1'b1;
      #32 scl_out <= 1'b0;
    end
  endtask : clocks
  task stop_cond();
    #16 sda_out <= 1'b0;
    #16 scl_out <= 1'b1;
    #32 sda_out <= 1'b1;
  endtask : stop_cond
endmodule : i2c_far_end

/* sim/tb_i2c_status_flags.sv */
// Self-checking bench for the status flag block
`timescale 1ns/1ps
module tb_i2c_status_flags;
  logic clk_in, rst_b_in, cyc, stb, we, mm, sm, txm, busy, acks, nack, col, gc, rxb;
  logic [7:0] adr, rxd, txd;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic ack, irq, txl, en, scl, sda;
  int n_fail = 0;
  int samples_checked = 0;

  i2c_status_flags DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq), .serial_clock_line_in(scl),
    .serial_data_line_in(sda), .master_mode_in(mm), .slave_mode_in(sm), .tx_mode_in(txm),
    .tx_busy_in(busy), .ack_sample_in(acks), .ack_nack_in(nack), .collision_in(col),
    .general_call_in(gc), .rx_byte_in(rxb), .rx_data_in(rxd), .tx_data_out(txd),
    .tx_load_out(txl), .controller_enable_out(en));
  i2c_far_end far (.scl_out(scl), .sda_out(sda));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task give_verdict();
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold request until ack is sampled, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait that never gets its ack
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task st(input logic [31:0] e);
    wb(1'b0, i2c_status_pkg::STATUS_OFS, 32'h0000_0000);
    chk(q, e);
  endtask : st

  task waitc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : waitc

  task pulse(input int s);
    @(posedge clk_in);
    case (s)
      0: acks <= 1'b1;
      1: col <= 1'b1;
      2: gc <= 1'b1;
      default: rxb <= 1'b1;
    endcase
    @(posedge clk_in);
    acks <= 1'b0;
    col <= 1'b0;
    gc <= 1'b0;
    rxb <= 1'b0;
  endtask : pulse

  task t_reset();
    st(32'h0000_0000);
    wb(1'b0, 8'hfc, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, i2c_status_pkg::STATUS_OFS, 32'hffff_ffff);
    st(32'h0000_0000);
  endtask : t_reset

  task t_ack();
    wb(1'b1, i2c_status_pkg::IRQ_MASK_OFS, 32'h0000_003f);
    nack <= 1'b1;
    pulse(0);
    st(32'h0000_8000);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(1'b0, i2c_status_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    waitc(2);
    chk({31'h0, irq}, 32'h0000_0000);
    nack <= 1'b0;
    pulse(0);
    st(32'h0000_0000);
    // Masked source must not reach the interrupt line
    wb(1'b1, i2c_status_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    nack <= 1'b1;
    pulse(0);
    waitc(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b0, i2c_status_pkg::IRQ_STATUS_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    nack <= 1'b0;
    pulse(0);
    st(32'h0000_0000);
  endtask : t_ack

  task t_col();
    wb(1'b1, i2c_status_pkg::CONTROL_OFS, 32'h0000_0001);
    chk({31'h0, en}, 32'h0000_0001);
    pulse(1);
    st(32'h0000_0400);
    wb(1'b1, i2c_status_pkg::STATUS_OFS, 32'h0000_0000);
    st(32'h0000_0000);
    pulse(1);
    wb(1'b1, i2c_status_pkg::CONTROL_OFS, 32'h0000_0000);
    chk({31'h0, en}, 32'h0000_0000);
    st(32'h0000_0000);
    wb(1'b1, i2c_status_pkg::CONTROL_OFS, 32'h0000_0001);
  endtask : t_col

  task t_gc();
    pulse(2);
    st(32'h0000_0200);
    wb(1'b1, i2c_status_pkg::STATUS_OFS, 32'h0000_0000);
    st(32'h0000_0200);
    far.start_cond();
    far.stop_cond();
    waitc(8);
    st(32'h0000_0000);
  endtask : t_gc

  task t_wcol();
    busy <= 1'b1;
    wb(1'b1, i2c_status_pkg::TX_BUFFER_OFS, 32'h0000_00a5);
    chk({31'h0, txl}, 32'h0000_0000);
    waitc(2);
    chk({24'h0, txd}, 32'h0000_0000);
    st(32'h0000_0080);
    busy <= 1'b0;
    wb(1'b1, i2c_status_pkg::TX_BUFFER_OFS, 32'h0000_003c);
    chk({31'h0, txl}, 32'h0000_0001);
    waitc(2);
    chk({24'h0, txd}, 32'h0000_003c);
    wb(1'b1, i2c_status_pkg::STATUS_OFS, 32'h0000_0000);
    st(32'h0000_0000);
  endtask : t_wcol

  task t_ovf();
    rxd <= 8'h11;
    pulse(3);
    rxd <= 8'h22;
    pulse(3);
    st(32'h0000_0040);
    wb(1'b0, i2c_status_pkg::RX_BUFFER_OFS, 32'h0000_0000);
    chk(q & 32'h0000_00ff, 32'h0000_0011);
    wb(1'b1, i2c_status_pkg::STATUS_OFS, 32'h0000_0000);
    txm <= 1'b1;
    pulse(3);
    pulse(3);
    st(32'h0000_0000);
  endtask : t_ovf

  task t_frames();
    mm <= 1'b1;
    wb(1'b1, i2c_status_pkg::TX_BUFFER_OFS, 32'h0000_005a);
    st(32'h0000_4000);
    far.start_cond();
    far.clocks(8);
    waitc(8);
    st(32'h0000_4000);
    far.clocks(1);
    waitc(8);
    st(32'h0000_0000);
    far.stop_cond();
    mm <= 1'b0;
    sm <= 1'b1;
    waitc(8);
    far.start_cond();
    far.clocks(8);
    waitc(8);
    st(32'h0000_2000);
    far.clocks(1);
    waitc(8);
    st(32'h0000_0000);
    far.stop_cond();
  endtask : t_frames

  // Whole run is a few hundred cycles; limit is generous
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    {rst_b_in, cyc, stb, we, mm, sm, txm, busy, acks, nack, col, gc, rxb} = 13'h0000;
    adr = 8'h00;
    rxd = 8'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_ack();
    t_col();
    t_gc();
    t_wcol();
    t_ovf();
    t_frames();
    give_verdict();
  end
endmodule : tb_i2c_status_flags
